/* File: verilog/drive_fault_trip_supervisor.v */
// trip supervisor: qualifies alarm flags and latches the drive trip
`timescale 1ns/1ps
`include "trip_map.vh"
// What this block does
// - overvoltage trips after 1.5 s, never disabled
// - missing pulses count only above discontinuity current
// - missing pulses persisting 30 s trip
// - missing-pulse trip enabled at reset, maskable
// - stall: slow, high current past delay trips
// - thermistor open trips after 15 s
// - heatsink over-temperature trips after 0.75 s
// - large frames: low fan supply raises heatsink
// - output short forces digital outputs low
// - disabled short trip keeps drive running
// - short trip enabled at reset, maskable
// - invalid reference data for 1.5 s alarms
// - reference alarm: receiver role, enabled, off at reset
// - sync failure or nonzero start ref: lockout
// - user alarm trips after 0.5 s, default off
// - network card watchdog ORed into user alarm
// - lock to 45-65 Hz supply within 750 ms
// - sync loss only running; at start lockout
// - two phases always, third at start only
// - running phase loss: cut current, trip after 2 s
// - stopped phase loss: start inhibits current, trip 3 s
// - feedback mismatch overridden by health override default
module drive_fault_trip_supervisor #(
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter STALL_W     = 16
) (
   input  wire               ref_clk,               // control clock, 40 MHz
   input  wire               rst_n,                 // synchronous reset, active low
   input  wire               trip_reset,            // explicit trip clear
   input  wire               running,               // drive is running
   input  wire               start_req,             // start command
   input  wire               stator_overvolt,       // stator volts above max plus margin
   input  wire               pulse_missing,         // at least one current pulse missing
   input  wire               current_above_disc,    // average current above discontinuity
   input  wire               missing_pulse_trip_en, // missing-pulse trip enable
   input  wire               speed_below_zero,      // rotor speed below zero interlock
   input  wire               current_above_stall,   // current above stall level
   input  wire [STALL_W-1:0] stall_delay_ms,        // stall delay time in ms
   input  wire               thermistor_open,       // sensor loop resistance high
   input  wire               large_frame,           // frame with external fan supply
   input  wire               heatsink_hot_a,        // heatsink sensor one hot
   input  wire               heatsink_hot_b,        // heatsink sensor two hot
   input  wire               fan_supply_low,        // fan supply below minimum
   input  wire               output_shorted,        // short on any digital output
   input  wire               user_supply_shorted,   // short on user_supply_output
   input  wire               output_short_trip_en,  // output short trip enable
   input  wire [7:0]         dout_req,              // requested digital outputs
   input  wire               reference_receiver_role, // serial_port_role is receiver
   input  wire               ref_data_invalid,      // received reference invalid
   input  wire               ref_exch_trip_en,      // reference exchange trip enable
   input  wire               supply_in_range,       // sync_supply_phases 45..65 Hz, clean
   input  wire               nonzero_speed_ref,     // external speed reference nonzero
   input  wire               zero_ref_start_en,     // zero-reference start interlock
   input  wire               user_alarm_sel,        // user alarm source enabled
   input  wire               user_alarm_src,        // user alarm source level
   input  wire               net_card_present,      // network card fitted
   input  wire               net_watchdog_timeout,  // network card watchdog expired
   input  wire               phase12_low,           // phases 1/2 below 75% nominal
   input  wire               phase3_low,            // phase 3 below 75% nominal
   input  wire               fb_mismatch,           // speed feedback mismatch flag
   input  wire [7:0]         health_override,       // global health override setting
   output reg                trip_q,                // drive trip, latched
   output reg  [3:0]         trip_code_q,           // cause of latched trip
   output reg                current_inhibit_q,     // stator current demand off
   output reg                sync_locked_q,         // supply synchronised
   output reg  [7:0]         dout_q,                // digital outputs
   output reg                short_alarm_q          // internal short alarm
);
   wire tick;
   wire [15:0] lim [0:9];
   assign lim[0] = `OVERVOLT_MS;
   assign lim[1] = `MISSPULSE_MS;
   assign lim[2] = stall_delay_ms;
   assign lim[3] = `THERMAL_MS;
   assign lim[4] = `HEATSINK_MS;
   assign lim[5] = `REFEXCH_MS;
   assign lim[6] = `LOCKOUT_MS;
   assign lim[7] = `USER_MS;
   assign lim[8] = `RIDE_MS;
   assign lim[9] = `SYNC_LOCK_MS;

   // ----------------------------------------
   // fault conditions
   // ----------------------------------------
   wire hs_hot   = heatsink_hot_a | heatsink_hot_b
                 | (large_frame & fan_supply_low);
   wire any_short = output_shorted | user_supply_shorted;
   wire user_in  = (user_alarm_sel & user_alarm_src)
                 | (net_card_present & net_watchdog_timeout);
   wire phase_low_run  = running & phase12_low;
   wire phase_low_stop = ~running & start_req & (phase12_low | phase3_low);
   wire lock_cond = (start_req & ~running & ~sync_locked_q)
                  | (start_req & ~running & nonzero_speed_ref & zero_ref_start_en)
                  | phase_low_stop;
   wire [9:0] cond;
   assign cond[0] = stator_overvolt;
   assign cond[1] = pulse_missing & current_above_disc;
   assign cond[2] = speed_below_zero & current_above_stall;
   assign cond[3] = thermistor_open;
   assign cond[4] = hs_hot;
   assign cond[5] = ref_data_invalid & reference_receiver_role;
   assign cond[6] = lock_cond;
   assign cond[7] = user_in;
   assign cond[8] = phase_low_run;
   assign cond[9] = supply_in_range;
   wire [9:0] exp;

   ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick_q  (tick)
   );

   genvar g;
   generate
      for (g = 0; g < 10; g = g + 1) begin : g_q
         qual_timer #(.W(16)) u_q (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .tick      (tick),
            .cond      (cond[g]),
            .limit     (lim[g]),
            .expired_q (exp[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // trip priority encode
   // ----------------------------------------
   function [3:0] pick;
      input [9:0] e;
      input       shrt;
      input       syncl;
      input       fbm;
      begin
         if (e[0])       pick = `CODE_OVERVOLT;
         else if (e[1])  pick = `CODE_MISSPULSE;
         else if (e[2])  pick = `CODE_STALL;
         else if (e[3])  pick = `CODE_THERMAL;
         else if (e[4])  pick = `CODE_HEATSINK;
         else if (shrt)  pick = `CODE_OUTSHORT;
         else if (e[5])  pick = `CODE_REFEXCH;
         else if (e[6])  pick = `CODE_LOCKOUT;
         else if (e[7])  pick = `CODE_USER;
         else if (syncl) pick = `CODE_SYNCLOSS;
         else if (e[8])  pick = `CODE_PHASELOSS;
         else if (fbm)   pick = `CODE_FBMISMATCH;
         else            pick = `CODE_NONE;
      end
   endfunction

   wire [9:0] en_exp = exp
                     & {4'hf, ref_exch_trip_en, 3'h7,
                        missing_pulse_trip_en, 1'b1};
   wire short_trip = any_short & output_short_trip_en;
   wire sync_loss  = running & ~supply_in_range;
   wire fb_trip    = fb_mismatch & ~health_override[`FB_OVR_BIT];
   wire [3:0] code = pick({1'b0, en_exp[8:0]}, short_trip, sync_loss, fb_trip);

   // ----------------------------------------
   // latched trip and outputs
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         trip_q            <= 1'b0;
         trip_code_q       <= `CODE_NONE;
         current_inhibit_q <= 1'b0;
         sync_locked_q     <= 1'b0;
         dout_q            <= 8'h00;
         short_alarm_q     <= 1'b0;
      end else begin
         // while tripped, a clear wins over a new trip; a trip still present re-latches the next cycle
         if (!trip_q && code != `CODE_NONE) begin
            trip_q      <= 1'b1;
            trip_code_q <= code;
         end else if (trip_reset) begin
            trip_q      <= 1'b0;
            trip_code_q <= `CODE_NONE;
         end
         if (exp[9])
            sync_locked_q <= 1'b1;
         else if (!supply_in_range)
            sync_locked_q <= 1'b0;
         current_inhibit_q <= phase_low_run | phase_low_stop | trip_q;
         short_alarm_q     <= any_short;
         dout_q            <= any_short ? 8'h00 : dout_req;
      end
   end
endmodule

/* File: common/trip_map.vh */
// timing constants and trip codes for the drive fault trip supervisor
`ifndef TRIP_MAP_VH
`define TRIP_MAP_VH
`define CLK_HZ            40000000
`define OVERVOLT_MS       16'h05dc
`define MISSPULSE_MS      16'h7530
`define THERMAL_MS        16'h3a98
`define HEATSINK_MS       16'h02ee
`define REFEXCH_MS        16'h05dc
`define LOCKOUT_MS        16'h0bb8
`define USER_MS           16'h01f4
`define SYNC_LOCK_MS      16'h02ee
`define RIDE_MS           16'h07d0
`define TICK_CYCLES       40000
`define HEALTH_OVR_RST    8'h02
`define FB_OVR_BIT        1
`define CODE_NONE         4'h0
`define CODE_OVERVOLT     4'h1
`define CODE_MISSPULSE    4'h2
`define CODE_STALL        4'h3
`define CODE_THERMAL      4'h4
`define CODE_HEATSINK     4'h5
`define CODE_OUTSHORT     4'h6
`define CODE_REFEXCH      4'h7
`define CODE_LOCKOUT      4'h8
`define CODE_USER         4'h9
`define CODE_SYNCLOSS     4'ha
`define CODE_PHASELOSS    4'hb
`define CODE_FBMISMATCH   4'hc
`endif

/* File: verilog/ms_tick.v */
// millisecond tick generator derived from the control clock
`timescale 1ns/1ps
`include "trip_map.vh"
module ms_tick #(
   parameter CYCLES = `TICK_CYCLES
) (
   input  wire ref_clk,   // control clock
   input  wire rst_n,     // synchronous reset, active low
   output reg  tick_q     // one-cycle pulse every millisecond
);
   reg [31:0] cnt_q;
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_q  <= 32'h0;
         tick_q <= 1'b0;
      end else if (cnt_q == CYCLES - 1) begin
         cnt_q  <= 32'h0;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h1;
         tick_q <= 1'b0;
      end
   end
endmodule

/* File: verilog/qual_timer.v */
// qualification timer: fires when a condition holds for LIMIT ms
`timescale 1ns/1ps
module qual_timer #(
   parameter W = 16
) (
   input  wire         ref_clk,  // control clock
   input  wire         rst_n,    // synchronous reset, active low
   input  wire         tick,     // millisecond tick
   input  wire         cond,     // fault condition
   input  wire [W-1:0] limit,    // qualification time in ms
   output reg          expired_q // condition held for limit
);
   reg [W-1:0] cnt_q;
   always @(posedge ref_clk) begin
      if (!rst_n || !cond) begin
         cnt_q     <= {W{1'b0}};   // restart when condition clears
         expired_q <= 1'b0;
      end else if (cnt_q >= limit) begin
         expired_q <= 1'b1;
      end else if (tick) begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* File: verification/drive_fault_trip_supervisor_asserts.sv */
// checker for the trip supervisor port behaviour
`timescale 1ns/1ps
module trip_checker (
   input wire       ref_clk,              // control clock
   input wire       rst_n,                // sync reset, active low
   input wire       trip_reset,           // trip clear
   input wire       running,              // drive running
   input wire       output_shorted,       // output short
   input wire       user_supply_shorted,  // supply short
   input wire       output_short_trip_en, // short trip enable
   input wire       supply_in_range,      // supply usable
   input wire       phase12_low,          // phase sag
   input wire       trip_q,               // latched trip
   input wire [3:0] trip_code_q,          // trip cause
   input wire       current_inhibit_q,    // current off
   input wire       sync_locked_q,        // synchronised
   input wire [7:0] dout_q,               // digital outputs
   input wire       short_alarm_q         // short alarm
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence shorted_s;
      output_shorted || user_supply_shorted;
   endsequence
   sequence held_s;
      trip_q && !trip_reset;
   endsequence
   short_dout_a: assert property (shorted_s |=> dout_q == 8'h00 && short_alarm_q)
      else $error("outputs not forced low on short");
   short_trip_a: assert property (shorted_s ##0 (output_short_trip_en && !trip_q)
      |-> ##[1:2] (trip_q && trip_code_q == 4'h6))
      else $error("short did not trip");
   trip_hold_a: assert property (held_s |=> trip_q)
      else $error("trip dropped without clear");
   code_hold_a: assert property (held_s |=> $stable(trip_code_q))
      else $error("trip cause changed");
   code_set_a: assert property (trip_q |-> trip_code_q != 4'h0)
      else $error("trip without cause");
   trip_inhibit_a: assert property (trip_q |=> current_inhibit_q)
      else $error("current not inhibited while tripped");
   sync_loss_a: assert property (running && !supply_in_range && sync_locked_q && !trip_q
      |-> ##[1:2] trip_q)
      else $error("sync loss not tripped");
   ride_cut_a: assert property (running && phase12_low && !trip_q
      |-> ##[1:2] current_inhibit_q)
      else $error("current not cut on phase loss");
endmodule
bind drive_fault_trip_supervisor trip_checker chk_i (.*);

/* File: verification/sense_model.sv */
// supply sensing model: in-range and phase levels from supply state
`timescale 1ns/1ps
module sense_model (
   input  wire supply_on,       // supply applied
   input  wire sag,             // phases 1/2 sag
   output wire supply_in_range, // supply usable
   output wire phase12_low,     // phases 1/2 low
   output wire phase3_low       // phase 3 low
);
   assign supply_in_range = supply_on;
   assign phase12_low     = !supply_on || sag;
   assign phase3_low      = !supply_on;
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the trip supervisor
`timescale 1ns/1ps
module tb_top;
   reg ref_clk = 0, rst_n = 0, trip_reset = 0, running = 0, start_req = 0;
   reg ovolt = 0, osh = 0, ush = 0, sh_en = 1, sel = 0, src = 0, ncard = 0, nwd = 0;
   reg supply_on = 0, sag = 0, fbm = 0;
   reg pmis = 0, disc = 0, mp_en = 1, slow = 0, stallc = 0, topen = 0, lframe = 0;
   reg hsa = 0, hsb = 0, fanlo = 0, rrole = 0, rinv = 0, rx_en = 0, nzref = 0, zr_en = 0;
   reg [7:0] dreq = 8'h00, hovr = 8'h02;
   reg [15:0] sdly = 16'h0064;
   wire sir, p12, p3, trip_q, inh, lock, sal;
   wire [3:0] code;
   wire [7:0] dout;
   integer err_count = 0, check_count = 0;
   initial forever #12.5 ref_clk = ~ref_clk;
   sense_model pm (.supply_on(supply_on), .sag(sag), .supply_in_range(sir),
      .phase12_low(p12), .phase3_low(p3));
   drive_fault_trip_supervisor #(.TICK_CYCLES(1)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .trip_reset(trip_reset), .running(running), .start_req(start_req),
      .stator_overvolt(ovolt), .pulse_missing(pmis), .current_above_disc(disc),
      .missing_pulse_trip_en(mp_en), .speed_below_zero(slow), .current_above_stall(stallc),
      .stall_delay_ms(sdly), .thermistor_open(topen), .large_frame(lframe),
      .heatsink_hot_a(hsa), .heatsink_hot_b(hsb), .fan_supply_low(fanlo),
      .output_shorted(osh), .user_supply_shorted(ush), .output_short_trip_en(sh_en),
      .dout_req(dreq), .reference_receiver_role(rrole), .ref_data_invalid(rinv),
      .ref_exch_trip_en(rx_en), .supply_in_range(sir), .nonzero_speed_ref(nzref),
      .zero_ref_start_en(zr_en), .user_alarm_sel(sel), .user_alarm_src(src),
      .net_card_present(ncard), .net_watchdog_timeout(nwd), .phase12_low(p12),
      .phase3_low(p3), .fb_mismatch(fbm), .health_override(hovr), .trip_q(trip_q),
      .trip_code_q(code), .current_inhibit_q(inh), .sync_locked_q(lock), .dout_q(dout),
      .short_alarm_q(sal));
   task cyc(input integer n); repeat (n) @(posedge ref_clk); endtask
   task chk(input [7:0] s, input [7:0] e);
      begin
         check_count = check_count + 1;
         if (s !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %0t seen %h want %h", $time, s, e);
         end
      end
   endtask
   task complete_run;
      begin
         if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task wt(input integer n);
      integer i;
      begin
         for (i = 0; i < n && trip_q !== 1'b1; i = i + 1) cyc(1);
         if (trip_q !== 1'b1) begin
            err_count = err_count + 1;
            $display("MISMATCH %0t no trip", $time);
            complete_run;
         end
      end
   endtask
   task clr;
      begin
         cyc(1); trip_reset <= 1; cyc(3); trip_reset <= 0; cyc(2);
         chk(trip_q, 0);
      end
   endtask
   task t_ovolt;
      begin
         cyc(1); ovolt <= 1; fbm <= 1; cyc(1000); ovolt <= 0; cyc(5);
         chk(trip_q, 0);
         chk(trip_q, 0);
         ovolt <= 1; cyc(1490);
         chk(trip_q, 0);
         wt(20); chk(code, 4'h1);
         ovolt <= 0; fbm <= 0; cyc(500); chk(code, 4'h1);
         clr;
      end
   endtask
   task t_short;
      begin
         cyc(1); dreq <= 8'ha5; cyc(3); chk(dout, 8'ha5);
         sh_en <= 0; osh <= 1; cyc(3);
         chk(dout, 8'h00); chk(sal, 1); chk(trip_q, 0);
         osh <= 0; ush <= 1; sh_en <= 1; wt(4); chk(code, 4'h6);
         ush <= 0; clr;
      end
   endtask
   task t_user;
      begin
         cyc(1); src <= 1; cyc(700); chk(trip_q, 0);
         sel <= 1; wt(510); chk(code, 4'h9);
         src <= 0; sel <= 0; clr;
         ncard <= 1; nwd <= 1; sel <= 1; wt(510); chk(code, 4'h9);
         nwd <= 0; sel <= 0; clr;
      end
   endtask
   task t_supply;
      begin
         cyc(1); supply_on <= 1; cyc(740); chk(lock, 0);
         cyc(15); chk(lock, 1);
         running <= 1; sag <= 1; cyc(1000);
         chk(inh, 1); chk(trip_q, 0);
         sag <= 0; cyc(5); chk(inh, 0);
         sag <= 1; cyc(1990); chk(trip_q, 0);
         wt(20); chk(code, 4'hb);
         sag <= 0; clr;
         supply_on <= 0; wt(4); chk(code, 4'ha);
         running <= 0; supply_on <= 1; clr;
      end
   endtask
   task t_fb;
      begin
         cyc(1); hovr <= 8'h00; fbm <= 1; wt(5); chk(code, 4'hc);
         fbm <= 0; hovr <= 8'h02; rst_n <= 0; cyc(3); rst_n <= 1; cyc(2);
         chk(trip_q, 0); chk(code, 4'h0);
      end
   endtask
   task t_mp;
      begin
         cyc(1); pmis <= 1; cyc(1000); disc <= 1; cyc(29990); chk(trip_q, 0);
         mp_en <= 0; cyc(30); chk(trip_q, 0);
         mp_en <= 1; wt(5); chk(code, 4'h2);
         pmis <= 0; disc <= 0; clr;
      end
   endtask
   task t_stall;
      begin
         cyc(1); slow <= 1; sdly <= 16'h0032; cyc(200); chk(trip_q, 0);
         stallc <= 1; cyc(40); chk(trip_q, 0); wt(20); chk(code, 4'h3);
         slow <= 0; stallc <= 0; clr;
      end
   endtask
   task t_heat;
      begin
         cyc(1); topen <= 1; cyc(14990); chk(trip_q, 0); wt(20); chk(code, 4'h4);
         topen <= 0; clr;
         hsa <= 1; cyc(740); chk(trip_q, 0); wt(20); chk(code, 4'h5);
         hsa <= 0; clr;
         hsb <= 1; wt(770); chk(code, 4'h5);
         hsb <= 0; clr;
         fanlo <= 1; cyc(800); chk(trip_q, 0);
         lframe <= 1; wt(770); chk(code, 4'h5);
         fanlo <= 0; lframe <= 0; clr;
      end
   endtask
   task t_refex;
      begin
         cyc(1); rinv <= 1; rrole <= 1; cyc(1600); chk(trip_q, 0);
         rrole <= 0; cyc(2); rx_en <= 1; cyc(1600); chk(trip_q, 0);
         rrole <= 1; cyc(1490); chk(trip_q, 0); wt(20); chk(code, 4'h7);
         rinv <= 0; rx_en <= 0; rrole <= 0; clr;
      end
   endtask
   task t_lock;
      begin
         cyc(760); start_req <= 1; nzref <= 1; cyc(3100); chk(trip_q, 0);
         zr_en <= 1; cyc(2990); chk(trip_q, 0); wt(20); chk(code, 4'h8);
         start_req <= 0; nzref <= 0; zr_en <= 0; clr;
         sag <= 1; start_req <= 1; cyc(3); chk(inh, 1);
         cyc(2987); chk(trip_q, 0); wt(20); chk(code, 4'h8);
         start_req <= 0; sag <= 0; clr;
         supply_on <= 0; cyc(3); start_req <= 1; wt(3020); chk(code, 4'h8);
         start_req <= 0; supply_on <= 1; clr;
      end
   endtask
   initial begin
      cyc(20); rst_n <= 1; cyc(2);
      chk(trip_q, 0); chk(dout, 8'h00);
      t_ovolt; t_fb; t_short; t_user; t_mp; t_stall; t_heat; t_refex; t_supply; t_lock;
      complete_run;
   end
endmodule
